/* ds1_pattern_framing_config.sv */
// DS1 test signal path: timing select, framer, line coder, pattern generator and checker
`timescale 1ns/1ps

module prbs_stage #(
   parameter int STAGES = 6,
   parameter int TAP = 5
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic en,
   input wire logic load_en,
   input wire logic load_bit,
   output logic predicted
);
   logic [STAGES-1:0] shift;

   // Loading the received bit makes a self-synchronising checker
   assign predicted = shift[STAGES-1] ^ shift[TAP-1];

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         shift <= '1;
      else if (en)
         shift <= {shift[STAGES-2:0], load_en ? load_bit : predicted};
   end
endmodule

module ds1_pattern_framing_config (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [31:0] rdata,
   input wire logic ext_clock_tick,
   input wire logic reference_tick,
   input wire logic [1:0] vt_mode,
   input wire logic rx_bit_en,
   input wire logic rx_bit,
   input wire logic rx_f_bit,
   output logic tx_bit_en,
   output logic tx_pos,
   output logic tx_neg,
   output logic tx_f_bit,
   output logic vt_path_ais
);
   logic [31:0] ctrl;
   logic write_refused;
   logic [31:0] error_count;
   logic [1:0] clock_sel;
   logic [2:0] framing_sel;
   logic [3:0] payload;
   logic use_b8zs;
   logic ext_payload;
   logic ais_payload;
   logic ctrl_write;
   logic ctrl_ok;

   assign clock_sel = ctrl[ds1_pattern_pkg::CLK_LSB +: 2];
   assign framing_sel = ctrl[ds1_pattern_pkg::FRM_LSB +: 3];
   assign payload = ctrl[ds1_pattern_pkg::PAY_LSB +: 4];
   assign use_b8zs = ctrl[ds1_pattern_pkg::CODE_BIT];
   assign ext_payload = payload == ds1_pattern_pkg::PAY_EXT;
   assign ais_payload = payload == ds1_pattern_pkg::PAY_AIS;
   assign ctrl_write = write_strobe && addr == ds1_pattern_pkg::ADDR_CTRL;
   assign ctrl_ok = ds1_pattern_pkg::config_allowed(wdata[ds1_pattern_pkg::FRM_LSB +: 3],
      wdata[ds1_pattern_pkg::PAY_LSB +: 4], vt_mode);

   // Refused settings leave the previous configuration in force
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl <= ds1_pattern_pkg::CTRL_RESET;
         write_refused <= 1'b0;
      end else if (ctrl_write) begin
         if (ctrl_ok)
            ctrl <= {22'h00_0000, wdata[ds1_pattern_pkg::PAY_LSB +: 4], wdata[ds1_pattern_pkg::PAY_LSB-1:0]};
         write_refused <= !ctrl_ok;
      end
   end

   // Internal 1.544 MHz rate from a fractional accumulator
   logic [15:0] int_acc;
   logic int_wrap;
   logic int_tick;
   assign int_wrap = (int_acc + ds1_pattern_pkg::DS1_KHZ) >= ds1_pattern_pkg::CLOCK_KHZ;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         int_acc <= 16'h0000;
         int_tick <= 1'b0;
      end else begin
         int_acc <= int_wrap ? int_acc + ds1_pattern_pkg::DS1_KHZ - ds1_pattern_pkg::CLOCK_KHZ
                             : int_acc + ds1_pattern_pkg::DS1_KHZ;
         int_tick <= int_wrap;
      end
   end

   logic sel_tick;
   always_comb begin
      case (clock_sel)
         ds1_pattern_pkg::CLK_INTERNAL: sel_tick = int_tick;
         ds1_pattern_pkg::CLK_EXTERNAL: sel_tick = ext_clock_tick;
         ds1_pattern_pkg::CLK_RECOVERED: sel_tick = rx_bit_en;
         default: sel_tick = reference_tick;
      endcase
   end
   assign tx_bit_en = ext_payload ? rx_bit_en : sel_tick;

   // Auto-match detector: F bits collected from the receive framer
   logic [23:0] rx_fbits;
   logic sf_seen;
   logic esf_seen;
   logic cand_esf;
   logic [5:0] detect_run;
   logic detect_valid;
   logic detected_esf;
   logic rx_f_en;
   assign rx_f_en = rx_bit_en && rx_f_bit;

   // Terminal bits sit on either phase of the history as new F bits shift in
   always_comb begin
      logic [5:0] fps;
      logic sf_odd;
      sf_seen = 1'b1;
      sf_odd = 1'b1;
      esf_seen = 1'b0;
      fps = 6'h00;
      for (int i = 0; i < 11; i++) begin
         if (rx_fbits[2*i] == rx_fbits[2*i+2])
            sf_seen = 1'b0;
         if (rx_fbits[2*i+1] == rx_fbits[2*i+3])
            sf_odd = 1'b0;
      end
      sf_seen = sf_seen || sf_odd;
      for (int p = 0; p < 4; p++) begin
         for (int i = 0; i < 6; i++)
            fps[5-i] = rx_fbits[23-p-4*i];
         for (int r = 0; r < 6; r++)
            if (fps == ((ds1_pattern_pkg::ESF_FPS << r) | (ds1_pattern_pkg::ESF_FPS >> (6 - r))))
               esf_seen = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_fbits <= 24'h00_0000;
         cand_esf <= 1'b0;
         detect_run <= 6'h00;
         detect_valid <= 1'b0;
         detected_esf <= 1'b0;
      end else if (rx_f_en) begin
         rx_fbits <= {rx_fbits[22:0], rx_bit};
         if (sf_seen == esf_seen || cand_esf != esf_seen) begin
            detect_run <= 6'h00;
            cand_esf <= esf_seen;
         end else if (detect_run != ds1_pattern_pkg::DETECT_HITS) begin
            detect_run <= detect_run + 6'h01;
         end else begin
            detect_valid <= 1'b1;
            detected_esf <= cand_esf;
         end
      end
   end

   // Transmit framing in force
   logic [2:0] tx_framing;
   logic tx_framed;
   assign tx_framing = framing_sel == ds1_pattern_pkg::FRM_AUTO_MATCH ?
      (detected_esf ? ds1_pattern_pkg::FRM_ESF : ds1_pattern_pkg::FRM_SF) : framing_sel;
   assign tx_framed = !ext_payload && !ais_payload && tx_framing != ds1_pattern_pkg::FRM_UNFRAMED &&
      tx_framing != ds1_pattern_pkg::FRM_UNFRAMED_T1C;

   logic [7:0] bit_pos;
   logic [3:0] fr12;
   logic [4:0] fr24;
   logic [6:0] fr72;
   logic f_slot;
   logic payload_adv;
   assign f_slot = tx_framed && bit_pos == 8'h00;
   assign payload_adv = tx_bit_en && !f_slot && !ext_payload;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         bit_pos <= 8'h00;
         fr12 <= 4'h0;
         fr24 <= 5'h00;
         fr72 <= 7'h00;
      end else if (tx_bit_en) begin
         bit_pos <= bit_pos == ds1_pattern_pkg::LAST_BIT_POS ? 8'h00 : bit_pos + 8'h01;
         if (bit_pos == ds1_pattern_pkg::LAST_BIT_POS) begin
            fr12 <= fr12 == ds1_pattern_pkg::LAST_SF_FRAME ? 4'h0 : fr12 + 4'h1;
            fr24 <= fr24 == ds1_pattern_pkg::LAST_ESF_FRAME ? 5'h00 : fr24 + 5'h01;
            fr72 <= fr72 == ds1_pattern_pkg::LAST_LOOP_FRAME ? 7'h00 : fr72 + 7'h01;
         end
      end
   end

   logic [11:0] mobile_fbits;
   logic fbit;
   assign mobile_fbits = ds1_pattern_pkg::SF_FBITS ^ ds1_pattern_pkg::MOBILE_FS_FLIP;

   always_comb begin
      case (tx_framing)
         ds1_pattern_pkg::FRM_ESF:
            if (fr24[1:0] == 2'h3)
               fbit = ds1_pattern_pkg::ESF_FPS[3'h5 - fr24[4:2]];
            else
               fbit = !fr24[0];
         ds1_pattern_pkg::FRM_SUBSCRIBER_LOOP_CARRIER:
            fbit = fr72[0] ? ds1_pattern_pkg::LOOP_FS[6'h23 - fr72[6:1]] : ds1_pattern_pkg::SF_FBITS[4'hb - fr12];
         ds1_pattern_pkg::FRM_MOBILE_MODIFIED_SF: fbit = mobile_fbits[4'hb - fr12];
         default: fbit = ds1_pattern_pkg::SF_FBITS[4'hb - fr12];
      endcase
   end

   // Pattern generators, one transmit and one checking copy each
   logic [ds1_pattern_pkg::PRBS_COUNT-1:0] tx_pred;
   logic [ds1_pattern_pkg::PRBS_COUNT-1:0] rx_pred;
   logic rx_payload_en;
   assign rx_payload_en = rx_bit_en && !rx_f_bit;

   for (genvar k = 0; k < ds1_pattern_pkg::PRBS_COUNT; k++) begin : gen_prbs
      prbs_stage #(
         .STAGES(ds1_pattern_pkg::PRBS_STAGES[k]),
         .TAP(ds1_pattern_pkg::PRBS_TAPS[k])
      ) tx_gen (
         .clock(clock),
         .rstn(rstn),
         .en(payload_adv),
         .load_en(1'b0),
         .load_bit(1'b0),
         .predicted(tx_pred[k])
      );
      prbs_stage #(
         .STAGES(ds1_pattern_pkg::PRBS_STAGES[k]),
         .TAP(ds1_pattern_pkg::PRBS_TAPS[k])
      ) rx_gen (
         .clock(clock),
         .rstn(rstn),
         .en(rx_payload_en),
         .load_en(1'b1),
         .load_bit(rx_bit),
         .predicted(rx_pred[k])
      );
   end

   // QRSS forces a one after fourteen zeros without disturbing the register
   logic [3:0] tx_zero_run;
   logic [3:0] rx_zero_run;
   logic qrss_bit;
   logic rx_qrss_force;
   logic rx_qrss_pred;
   assign qrss_bit = tx_zero_run >= ds1_pattern_pkg::QRSS_MAX_ZEROS || tx_pred[ds1_pattern_pkg::QRSS_INDEX];
   assign rx_qrss_force = rx_zero_run >= ds1_pattern_pkg::QRSS_MAX_ZEROS;

   prbs_stage #(
      .STAGES(ds1_pattern_pkg::PRBS_STAGES[ds1_pattern_pkg::QRSS_INDEX]),
      .TAP(ds1_pattern_pkg::PRBS_TAPS[ds1_pattern_pkg::QRSS_INDEX])
   ) rx_qrss (
      .clock(clock),
      .rstn(rstn),
      .en(rx_payload_en),
      .load_en(1'b1),
      .load_bit(rx_qrss_force ? rx_qrss_pred : rx_bit),
      .predicted(rx_qrss_pred)
   );

   logic alt_phase;
   logic rx_last;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tx_zero_run <= 4'h0;
         rx_zero_run <= 4'h0;
         alt_phase <= 1'b1;
         rx_last <= 1'b0;
      end else begin
         if (payload_adv) begin
            alt_phase <= !alt_phase;
            tx_zero_run <= qrss_bit ? 4'h0 : tx_zero_run + 4'h1;
         end
         if (rx_payload_en) begin
            rx_last <= rx_bit;
            rx_zero_run <= rx_bit ? 4'h0 : (rx_qrss_force ? rx_zero_run : rx_zero_run + 4'h1);
         end
      end
   end

   logic pay_bit;
   logic rx_expect;
   logic check_on;
   always_comb begin
      check_on = 1'b1;
      case (payload)
         ds1_pattern_pkg::PAY_QRSS: begin
            pay_bit = qrss_bit;
            rx_expect = rx_qrss_force || rx_qrss_pred;
         end
         ds1_pattern_pkg::PAY_PRBS6: begin
            pay_bit = tx_pred[0];
            rx_expect = rx_pred[0];
         end
         ds1_pattern_pkg::PAY_PRBS9: begin
            pay_bit = tx_pred[1];
            rx_expect = rx_pred[1];
         end
         ds1_pattern_pkg::PAY_PRBS11: begin
            pay_bit = tx_pred[2];
            rx_expect = rx_pred[2];
         end
         ds1_pattern_pkg::PAY_PRBS15: begin
            pay_bit = tx_pred[3];
            rx_expect = rx_pred[3];
         end
         ds1_pattern_pkg::PAY_PRBS20: begin
            pay_bit = tx_pred[4];
            rx_expect = rx_pred[4];
         end
         ds1_pattern_pkg::PAY_PRBS23: begin
            pay_bit = tx_pred[5];
            rx_expect = rx_pred[5];
         end
         ds1_pattern_pkg::PAY_ZEROS: begin
            pay_bit = 1'b0;
            rx_expect = 1'b0;
         end
         ds1_pattern_pkg::PAY_ALT: begin
            pay_bit = alt_phase;
            rx_expect = !rx_last;
         end
         ds1_pattern_pkg::PAY_EXT: begin
            pay_bit = rx_bit;
            rx_expect = rx_bit;
            check_on = 1'b0;
         end
         default: begin
            pay_bit = 1'b1;
            rx_expect = 1'b1;
         end
      endcase
   end

   // Line coder: eight-bit window feeds B8ZS substitution
   logic tx_bit_val;
   logic [7:0] b8_win;
   logic [7:0] f_win;
   logic sub_act;
   logic [2:0] sub_step;
   logic last_pos;
   logic sub_start;
   logic in_sub;
   logic [2:0] step;
   logic is_v;
   logic mark;
   logic pulse;
   logic pol;
   assign tx_bit_val = ext_payload ? rx_bit : (f_slot ? fbit : pay_bit);
   assign sub_start = use_b8zs && !sub_act && b8_win == 8'h00;
   assign in_sub = sub_act || sub_start;
   assign step = sub_act ? sub_step : 3'h0;
   assign is_v = in_sub && (step == ds1_pattern_pkg::B8_V1 || step == ds1_pattern_pkg::B8_V2);
   assign mark = in_sub ? (step == ds1_pattern_pkg::B8_B1 || step == ds1_pattern_pkg::B8_B2) : b8_win[7];
   assign pulse = mark || is_v;
   assign pol = is_v ? last_pos : !last_pos;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         b8_win <= 8'hff;
         f_win <= 8'h00;
         sub_act <= 1'b0;
         sub_step <= 3'h0;
         last_pos <= 1'b0;
         tx_pos <= 1'b0;
         tx_neg <= 1'b0;
         tx_f_bit <= 1'b0;
      end else if (tx_bit_en) begin
         b8_win <= {b8_win[6:0], tx_bit_val};
         f_win <= {f_win[6:0], f_slot};
         tx_f_bit <= f_win[7];
         tx_pos <= pulse && pol;
         tx_neg <= pulse && !pol;
         if (pulse)
            last_pos <= pol;
         if (sub_start) begin
            sub_act <= 1'b1;
            sub_step <= 3'h1;
         end else if (sub_act) begin
            sub_act <= sub_step != ds1_pattern_pkg::B8_B2;
            sub_step <= sub_step + 3'h1;
         end
      end
   end

   // Pattern checker: sync after clean run, leaky bucket for loss
   logic pattern_sync;
   logic [5:0] good_run;
   logic [5:0] bucket;
   logic mismatch;
   logic count_error;
   logic err_read;
   assign mismatch = rx_payload_en && check_on && rx_bit != rx_expect;
   assign count_error = mismatch && pattern_sync;
   assign err_read = read_strobe && addr == ds1_pattern_pkg::ADDR_ERRCNT;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pattern_sync <= 1'b0;
         good_run <= 6'h00;
         bucket <= 6'h00;
      end else if (!check_on) begin
         pattern_sync <= 1'b0;
         good_run <= 6'h00;
         bucket <= 6'h00;
      end else if (rx_payload_en) begin
         if (!pattern_sync) begin
            good_run <= mismatch ? 6'h00 : good_run + 6'h01;
            pattern_sync <= !mismatch && good_run == ds1_pattern_pkg::SYNC_GOOD_BITS - 6'h01;
            bucket <= 6'h00;
         end else if (mismatch) begin
            bucket <= bucket + ds1_pattern_pkg::ERR_WEIGHT;
            pattern_sync <= bucket + ds1_pattern_pkg::ERR_WEIGHT < ds1_pattern_pkg::LOSS_LEVEL;
            good_run <= 6'h00;
         end else if (bucket != 6'h00) begin
            bucket <= bucket - 6'h01;
         end
      end
   end

   // Error counter clears on read; an error in the read cycle survives
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn)
         error_count <= 32'h0000_0000;
      else if (err_read)
         error_count <= {31'h0000_0000, count_error};
      else if (count_error && error_count != 32'hffff_ffff)
         error_count <= error_count + 32'h0000_0001;
   end

   logic [2:0] timing_code;
   logic [31:0] status_word;
   logic [31:0] read_mux;
   assign timing_code = ext_payload ? ds1_pattern_pkg::TIMING_FROM_INPUT : {1'b0, clock_sel};
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[ds1_pattern_pkg::ST_SYNC] = pattern_sync;
      status_word[ds1_pattern_pkg::ST_DET_VALID] = detect_valid;
      status_word[ds1_pattern_pkg::ST_DET_ESF] = detected_esf;
      status_word[ds1_pattern_pkg::ST_REFUSED] = write_refused;
      status_word[ds1_pattern_pkg::ST_TIMING_LSB +: 3] = timing_code;
   end
   assign read_mux = addr == ds1_pattern_pkg::ADDR_CTRL ? ctrl :
                     addr == ds1_pattern_pkg::ADDR_STATUS ? status_word :
                     addr == ds1_pattern_pkg::ADDR_ERRCNT ? error_count : 32'h0000_0000;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata <= 32'h0000_0000;
         vt_path_ais <= 1'b0;
      end else begin
         rdata <= read_strobe ? read_mux : 32'h0000_0000;
         vt_path_ais <= ais_payload && vt_mode != ds1_pattern_pkg::VT_NONE;
      end
   end
endmodule

/* ds1_pattern_pkg.sv */
// Constants, register map and mode encodings for the DS1 pattern and framing block
package ds1_pattern_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_ERRCNT = 8'h08;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int CLK_LSB = 0;
   localparam int FRM_LSB = 2;
   localparam int CODE_BIT = 5;
   localparam int PAY_LSB = 6;
   localparam int ST_SYNC = 0;
   localparam int ST_DET_VALID = 1;
   localparam int ST_DET_ESF = 2;
   localparam int ST_REFUSED = 3;
   localparam int ST_TIMING_LSB = 4;
   typedef enum logic [1:0] {CLK_INTERNAL, CLK_EXTERNAL, CLK_RECOVERED, CLK_REFERENCE} transmit_clock_source_t;
   localparam logic [2:0] TIMING_FROM_INPUT = 3'h4;
   typedef enum logic [2:0] {FRM_SF, FRM_ESF, FRM_SUBSCRIBER_LOOP_CARRIER, FRM_UNFRAMED, FRM_MOBILE_MODIFIED_SF,
      FRM_UNFRAMED_T1C, FRM_AUTO_MATCH} framing_t;
   typedef enum logic [3:0] {PAY_QRSS, PAY_PRBS6, PAY_PRBS9, PAY_PRBS11, PAY_PRBS15, PAY_PRBS20, PAY_PRBS23,
      PAY_ZEROS, PAY_ONES, PAY_ALT, PAY_AIS, PAY_EXT} payload_t;
   typedef enum logic [1:0] {VT_NONE, VT_ASYNC, VT_BYTE_SYNC} vt_mode_t;
   localparam logic [15:0] CLOCK_KHZ = 16'hc350;
   localparam logic [15:0] DS1_KHZ = 16'h0608;
   localparam logic [7:0] LAST_BIT_POS = 8'hc0;
   localparam logic [3:0] LAST_SF_FRAME = 4'hb;
   localparam logic [4:0] LAST_ESF_FRAME = 5'h17;
   localparam logic [6:0] LAST_LOOP_FRAME = 7'h47;
   localparam logic [11:0] SF_FBITS = 12'h8dc;
   localparam logic [11:0] MOBILE_FS_FLIP = 12'h555;
   localparam logic [5:0] ESF_FPS = 6'h0b;
   localparam logic [35:0] LOOP_FS = 36'h1_c71c_71c7;
   localparam int PRBS_COUNT = 6;
   localparam int PRBS_STAGES [PRBS_COUNT] = '{6, 9, 11, 15, 20, 23};
   localparam int PRBS_TAPS [PRBS_COUNT] = '{5, 5, 9, 14, 17, 18};
   localparam int QRSS_INDEX = 4;
   localparam logic [3:0] QRSS_MAX_ZEROS = 4'he;
   localparam logic [2:0] B8_V1 = 3'h3;
   localparam logic [2:0] B8_B1 = 3'h4;
   localparam logic [2:0] B8_V2 = 3'h6;
   localparam logic [2:0] B8_B2 = 3'h7;
   localparam logic [5:0] SYNC_GOOD_BITS = 6'h20;
   localparam logic [5:0] ERR_WEIGHT = 6'h04;
   localparam logic [5:0] LOSS_LEVEL = 6'h20;
   localparam logic [5:0] DETECT_HITS = 6'h30;

   function automatic logic config_allowed(input logic [2:0] frm, input logic [3:0] pay, input logic [1:0] vt);
      logic ok;
      ok = (frm <= FRM_AUTO_MATCH) && (pay <= PAY_EXT) && (vt <= VT_BYTE_SYNC);
      if (vt == VT_BYTE_SYNC && (frm == FRM_SUBSCRIBER_LOOP_CARRIER || frm == FRM_UNFRAMED || pay == PAY_ZEROS))
         ok = 1'b0;
      if (vt != VT_NONE && (frm == FRM_MOBILE_MODIFIED_SF || frm == FRM_AUTO_MATCH))
         ok = 1'b0;
      return ok;
   endfunction
endpackage

/* ds1_far_end.sv */
// Far-end DS1 equipment model: loops the line signal back at its own bit rate
`timescale 1ns/1ps
module ds1_far_end (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] gap,
   input wire logic inject,
   input wire logic tx_pos,
   input wire logic tx_neg,
   input wire logic tx_f_bit,
   output logic rx_bit_en,
   output logic rx_bit,
   output logic rx_f_bit
);
   logic [7:0] cnt;
   // Between bits the data lines toggle so that no stale value looks valid
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt <= 8'h00;
         rx_bit_en <= 1'b0;
         rx_bit <= 1'b0;
         rx_f_bit <= 1'b0;
      end else if (cnt >= gap) begin
         cnt <= 8'h00;
         rx_bit_en <= 1'b1;
         rx_bit <= (tx_pos | tx_neg) ^ inject;
         rx_f_bit <= tx_f_bit;
      end else begin
         cnt <= cnt + 8'h01;
         rx_bit_en <= 1'b0;
         rx_bit <= ~rx_bit;
         rx_f_bit <= ~rx_f_bit;
      end
   end
endmodule

/* ds1_pattern_framing_config_monitor.sv */
// Port-level assertions for the DS1 pattern and framing block
`timescale 1ns/1ps
module ds1_port_checker (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [31:0] rdata,
   input wire logic [1:0] vt_mode,
   input wire logic tx_bit_en,
   input wire logic tx_pos,
   input wire logic tx_neg,
   input wire logic tx_f_bit,
   input wire logic vt_path_ais
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   a_rails_hold: assert property (!$past(tx_bit_en) |-> $stable(tx_pos) && $stable(tx_neg))
      else $error("line rails moved without a bit tick");
   a_one_rail: assert property (!(tx_pos && tx_neg))
      else $error("both rails high");
   a_fbit_tick: assert property ($rose(tx_f_bit) |-> $past(tx_bit_en))
      else $error("framing bit without a bit tick");
   a_vt_ais_flag: assert property (vt_path_ais |-> $past(vt_mode) != 2'h0)
      else $error("path alarm flag outside carrier mode");
   a_ctrl_readback: assert property (write_strobe && addr == 8'h00 && vt_mode == 2'h0 && wdata[4:2] <= 3'h6
      && wdata[9:6] <= 4'hb ##1 read_strobe && addr == 8'h00 |=> rdata == {22'h00_0000, $past(wdata[9:0], 2)})
      else $error("control word not read back");
   a_refuse_vt: assert property (write_strobe && addr == 8'h00 && vt_mode != 2'h0 && wdata[4:2] == 3'h4
      ##1 read_strobe && addr == 8'h04 |=> rdata[3])
      else $error("mobile framing accepted in carrier mode");
   a_refuse_zeros: assert property (write_strobe && addr == 8'h00 && vt_mode == 2'h2 && wdata[9:6] == 4'h7
      ##1 read_strobe && addr == 8'h04 |=> rdata[3])
      else $error("zeros payload accepted in byte-sync mode");
   a_ext_timing: assert property (write_strobe && addr == 8'h00 && vt_mode == 2'h0 && wdata[4:2] <= 3'h6
      && wdata[9:6] == 4'hb ##1 read_strobe && addr == 8'h04 |=> rdata[6:4] == 3'h4)
      else $error("external payload not timed from input");
endmodule
bind ds1_pattern_framing_config ds1_port_checker chk (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
   .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata), .vt_mode(vt_mode), .tx_bit_en(tx_bit_en),
   .tx_pos(tx_pos), .tx_neg(tx_neg), .tx_f_bit(tx_f_bit), .vt_path_ais(vt_path_ais));

/* ds1_pattern_framing_config_bench.sv */
// Self-checking bench for the DS1 pattern and framing block
`timescale 1ns/1ps
module ds1_pattern_framing_config_bench;
   logic clock, rstn, write_strobe, read_strobe, ext_clock_tick, reference_tick, inject;
   logic rx_bit_en, rx_bit, rx_f_bit, tx_bit_en, tx_pos, tx_neg, tx_f_bit, vt_path_ais;
   logic [7:0] addr, gap, tk;
   logic [31:0] wdata, rdata, v;
   logic [1:0] vt_mode;
   int fails, n_checks, cyc, bad, n;
   int pt[9][4] = '{'{0, 1, 0, 0}, '{1, 0, 5, 6}, '{2, 0, 5, 9}, '{3, 0, 9, 11}, '{4, 0, 14, 15},
      '{5, 0, 17, 20}, '{6, 0, 18, 23}, '{8, 2, 0, 0}, '{9, 3, 0, 0}};
   int rf[5][3] = '{'{2, 2, 8}, '{2, 3, 8}, '{1, 4, 8}, '{1, 6, 8}, '{2, 0, 7}};
   ds1_pattern_framing_config uut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
      .write_strobe(write_strobe), .read_strobe(read_strobe), .rdata(rdata), .ext_clock_tick(ext_clock_tick),
      .reference_tick(reference_tick), .vt_mode(vt_mode), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit),
      .rx_f_bit(rx_f_bit), .tx_bit_en(tx_bit_en), .tx_pos(tx_pos), .tx_neg(tx_neg), .tx_f_bit(tx_f_bit),
      .vt_path_ais(vt_path_ais));
   ds1_far_end far (.clock(clock), .rstn(rstn), .gap(gap), .inject(inject), .tx_pos(tx_pos), .tx_neg(tx_neg),
      .tx_f_bit(tx_f_bit), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .rx_f_bit(rx_f_bit));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Rear clock and reference ticks at unrelated rates, plus the run limit
   always @(posedge clock) begin
      tk <= tk + 8'h01;
      ext_clock_tick <= (tk % 8'h07) == 8'h00;
      reference_tick <= (tk % 8'h0b) == 8'h00;
      cyc = cyc + 1;
      if (cyc == 90000) begin
         fails = fails + 1;
         finish_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      addr <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      @(posedge clock);
      v = rdata;
   endtask
   function automatic logic [31:0] cw(input int src, input int frm, input int code, input int pay);
      return 32'(pay * 64 + code * 32 + frm * 4 + src);
   endfunction
   task automatic cfg(input logic [1:0] vt, input logic [31:0] d, input logic refused);
      vt_mode <= vt;
      @(posedge clock);
      wr(8'h00, d);
      rd(8'h04);
      check(v[3], refused);
   endtask
   // Kinds: 0 recurrence, 1 zero-run limit, 2 ones, 3 alternating, 4 zeros, 5 substituted zeros
   task automatic stream(input int kind, input int a, input int b, input logic framed);
      int run, fl;
      logic [31:0] h;
      bad = 0;
      run = 0;
      fl = -1;
      h = 32'h0000_0000;
      for (n = 0; n < 500; n++) begin
         do @(posedge clock); while (rx_bit_en !== 1'b1);
         if (n < 40) continue;
         if (fl >= 0) fl++;
         if (rx_f_bit) begin
            if (!framed || (fl > 0 && fl != 193)) bad++;
            fl = 0;
            continue;
         end
         h = {h[30:0], rx_bit};
         run = rx_bit ? 0 : run + 1;
         if (n < 72) continue;
         case (kind)
            0: if (h[0] !== (h[a] ^ h[b])) bad++;
            1: if (run > 14) bad++;
            2: if (h[0] !== 1'b1) bad++;
            3: if (h[0] === h[1]) bad++;
            4: if (h[0] !== 1'b0) bad++;
            5: if ($countones(h[7:0]) != 4) bad++;
            default: ;
         endcase
      end
      check(bad, 0);
   endtask
   initial begin
      rstn = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      write_strobe = 1'b0;
      read_strobe = 1'b0;
      vt_mode = 2'h0;
      gap = 8'h02;
      inject = 1'b0;
      tk = 8'h00;
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      rd(8'h00);
      check(v, 32'h0000_0000);
      rd(8'h0c);
      check(v, 32'h0000_0000);
      wr(8'h00, cw(2, 0, 0, 8));
      rd(8'h00);
      check(v, cw(2, 0, 0, 8));
      foreach (rf[i]) begin
         cfg(2'(rf[i][0]), cw(2, rf[i][1], 0, rf[i][2]), 1'b1);
         rd(8'h00);
         check(v, cw(2, 0, 0, 8));
      end
      for (int s = 1; s < 4; s++) begin
         cfg(2'h0, cw(s, 0, 0, 8), 1'b0);
         check(v[6:4], s);
         bad = 0;
         repeat (60) begin
            @(posedge clock);
            if (tx_bit_en !== (s == 1 ? ext_clock_tick : s == 2 ? rx_bit_en : reference_tick)) bad++;
         end
         check(bad, 0);
      end
      cfg(2'h0, cw(0, 0, 0, 8), 1'b0);
      n = 0;
      repeat (1000) begin
         @(posedge clock);
         n += tx_bit_en;
      end
      check(n >= 30 && n <= 31, 1);
      cfg(2'h0, cw(0, 0, 0, 11), 1'b0);
      check(v[6:4], 3'h4);
      stream(6, 0, 0, 1'b0);
      foreach (pt[i]) begin
         cfg(2'h0, cw(2, 0, 0, pt[i][0]), 1'b0);
         stream(pt[i][1], pt[i][2], pt[i][3], 1'b1);
      end
      for (int f = 0; f < 6; f++) begin
         cfg(2'h0, cw(2, f, 0, 8), 1'b0);
         stream(2, 0, 0, f != 3 && f != 5);
      end
      cfg(2'h0, cw(2, 0, 0, 10), 1'b0);
      stream(2, 0, 0, 1'b0);
      cfg(2'h1, cw(2, 0, 0, 10), 1'b0);
      check(vt_path_ais, 1'b1);
      cfg(2'h0, cw(2, 3, 0, 7), 1'b0);
      check(vt_path_ais, 1'b0);
      stream(4, 0, 0, 1'b0);
      cfg(2'h0, cw(2, 3, 1, 7), 1'b0);
      stream(5, 0, 0, 1'b0);
      cfg(2'h0, cw(2, 3, 0, 8), 1'b0);
      repeat (300) @(posedge clock);
      rd(8'h04);
      check(v[0], 1'b1);
      rd(8'h08);
      inject <= 1'b1;
      @(posedge clock);
      do @(posedge clock); while (rx_bit_en !== 1'b1);
      inject <= 1'b0;
      repeat (10) @(posedge clock);
      rd(8'h08);
      check(v, 32'h0000_0001);
      rd(8'h08);
      check(v, 32'h0000_0000);
      gap <= 8'h01;
      cfg(2'h0, cw(2, 6, 0, 8), 1'b0);
      repeat (32000) @(posedge clock);
      rd(8'h04);
      check(v[2:1], 2'b01);
      finish_test();
   end
endmodule
